// ---- design/mic_pick.sv ----
// Picks one pending source of a level, fixed order or round-robin.
module mic_pick
    import mic_pkg::*;
(
    mic_pick_if.picker p
);

    // ------------------------------------------------------------
    // Search from a start index with wrap-around
    // ------------------------------------------------------------
    function automatic logic [IDX_W:0] pick_first(input logic [NSRC-1:0] m, input logic [IDX_W-1:0] s);
        logic [IDX_W:0] r;
        int j;
        r = '0;
        j = 0;
        for (int k = NSRC - 1; k >= 0; k--)
        begin
            j = (int'(s) + k) % NSRC;
            if (m[j])
                r = {1'b1, IDX_W'(j)};
        end
        return r;
    endfunction

    logic [IDX_W-1:0] start;
    logic [IDX_W:0] res;

    // Fixed mode starts at index 0, the lowest vector; round-robin starts past the last one served.
    always_comb
    begin
        start = '0;
        if (p.rr_en && p.last != IDX_W'(NSRC - 1))
            start = IDX_W'(p.last + 1'b1);
        res = pick_first(p.mask, start);
    end

    assign p.vld = res[IDX_W];
    assign p.idx = res[IDX_W-1:0];

endmodule

// ---- design/mic_pick_if.sv ----
// Carrier between the controller and one per-level request picker.
interface mic_pick_if;
    import mic_pkg::*;

    logic [NSRC-1:0] mask;
    logic rr_en;
    logic [IDX_W-1:0] last;
    logic vld;
    logic [IDX_W-1:0] idx;

    modport picker (input mask, input rr_en, input last, output vld, output idx);
    modport ctrl (output mask, output rr_en, output last, input vld, input idx);
endinterface

// ---- design/mic_pkg.sv ----
// Constants, vector table and types shared by the multilevel interrupt controller.
package mic_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int VEC_W = 16;
    localparam int NSRC = 23;
    localparam int IDX_W = $clog2(NSRC);
    localparam int NLVL = 3;

    // ------------------------------------------------------------
    // Level codes per source
    // ------------------------------------------------------------
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_LO = 2'h1;
    localparam logic [1:0] LVL_MED = 2'h2;
    localparam logic [1:0] LVL_HI = 2'h3;
    localparam int LVL_FLD_W = 2;

    // ------------------------------------------------------------
    // Vector bases (word addresses)
    // ------------------------------------------------------------
    localparam logic [VEC_W-1:0] RESET_ENTRY = 16'h0000;
    localparam logic [VEC_W-1:0] CRYSTAL_FAIL_VECTOR = 16'h0002;
    localparam logic [VEC_W-1:0] PORT_C_IRQ_VECTOR_BASE = 16'h0004;
    localparam logic [VEC_W-1:0] PORT_R_IRQ_VECTOR_BASE = 16'h0008;
    localparam logic [VEC_W-1:0] DMA_VECTOR_BASE = 16'h000c;
    localparam logic [VEC_W-1:0] RTC_VECTOR_BASE = 16'h0014;
    localparam logic [VEC_W-1:0] TWOWIRE_PORTC_VECTOR_BASE = 16'h0018;
    localparam logic [VEC_W-1:0] TIMER0_PORTC_VECTOR_BASE = 16'h001c;
    localparam logic [VEC_W-1:0] TIMER1_PORTC_VECTOR_BASE = 16'h0028;
    localparam logic [VEC_W-1:0] SPI_PORTC_VECTOR = 16'h0030;
    localparam logic [VEC_W-1:0] SERIAL0_PORTC_VECTOR_BASE = 16'h0032;
    localparam logic [VEC_W-1:0] AES_VECTOR = 16'h003e;
    localparam logic [VEC_W-1:0] NONVOLATILE_MEM_VECTOR_BASE = 16'h0040;
    localparam logic [VEC_W-1:0] PORT_B_IRQ_VECTOR_BASE = 16'h0044;
    localparam logic [VEC_W-1:0] TIMER0_PORTE_VECTOR_BASE = 16'h005e;
    localparam logic [VEC_W-1:0] USB_VECTOR_BASE = 16'h00fa;

    // Offsets of the second, third and fourth interrupt within a peripheral.
    localparam logic [VEC_W-1:0] VOFS1 = 16'h0002;
    localparam logic [VEC_W-1:0] VOFS2 = 16'h0004;
    localparam logic [VEC_W-1:0] VOFS3 = 16'h0006;

    // Source index order follows ascending vector address.
    localparam logic [VEC_W-1:0] SRC_VEC [NSRC] = '{
        PORT_C_IRQ_VECTOR_BASE, PORT_C_IRQ_VECTOR_BASE + VOFS1,
        PORT_R_IRQ_VECTOR_BASE, PORT_R_IRQ_VECTOR_BASE + VOFS1,
        DMA_VECTOR_BASE, DMA_VECTOR_BASE + VOFS1, DMA_VECTOR_BASE + VOFS2, DMA_VECTOR_BASE + VOFS3,
        RTC_VECTOR_BASE, RTC_VECTOR_BASE + VOFS1,
        TWOWIRE_PORTC_VECTOR_BASE, TWOWIRE_PORTC_VECTOR_BASE + VOFS1,
        TIMER0_PORTC_VECTOR_BASE, TIMER0_PORTC_VECTOR_BASE + VOFS1,
        TIMER1_PORTC_VECTOR_BASE,
        SPI_PORTC_VECTOR,
        SERIAL0_PORTC_VECTOR_BASE,
        AES_VECTOR,
        NONVOLATILE_MEM_VECTOR_BASE, NONVOLATILE_MEM_VECTOR_BASE + VOFS1,
        PORT_B_IRQ_VECTOR_BASE,
        TIMER0_PORTE_VECTOR_BASE,
        USB_VECTOR_BASE
    };

    // ------------------------------------------------------------
    // Wake-up hold and power state
    // ------------------------------------------------------------
    localparam logic [2:0] WAKE_HOLD_CYCLES = 3'h4;

    typedef enum logic [1:0] {
        MIC_RUN = 2'b00,
        MIC_NAP = 2'b01,
        MIC_HOLD = 2'b11
    } mic_pwr_e;

endpackage

// ---- design/multilevel_irq_ctrl.sv ----
// Multilevel interrupt controller: level ranking, vector forming, in-service tracking and wake hold.
//
// What this block does
// - Each source picks low, medium or high level independently.
// - A medium request may preempt a running low-level handler.
// - A high request may preempt running medium and low handlers.
// - Within one level the lowest vector address wins.
// - Low level optionally uses round-robin so every request is served in bounded time.
// - Non-maskable requests bypass level masking.
// - On acknowledge the core loads its program counter with the granted vector.
// - Vector is peripheral base plus interrupt offset; single-interrupt peripherals use the base.
// - Vectors are word addresses in program memory.
// - The vector table can be moved to the boot loader section.
// - Reset entry at word 0x000, crystal failure non-maskable vector at 0x002.
// - Port C base 0x004, port R 0x008, port B 0x044.
// - DMA base 0x00C, real-time counter base 0x014.
// - Timer bases 0x01C, 0x028 and 0x05E.
// - Port C two-wire base 0x018, SPI 0x030, first serial base 0x032.
// - Crypto vector 0x03E, nonvolatile memory base 0x040.
// - USB base at 0x0FA, the highest base.
// - Each source has its own enable, level and distinct vector.
// - A wake-up interrupt holds the core four cycles before it resumes.
// - Pending higher-priority requests at wake-up are served first, in priority order.
module multilevel_irq_ctrl
    import mic_pkg::*;
#(
    parameter logic [VEC_W-1:0] BOOT_BASE = 16'h4000
)
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [NSRC-1:0] IRQ_REQ,
    input wire logic [NSRC-1:0] IRQ_EN,
    input wire logic [LVL_FLD_W*NSRC-1:0] IRQ_LVL,
    input wire logic [NLVL-1:0] LVL_EN,
    input wire logic RR_EN,
    input wire logic NMI_REQ,
    input wire logic BOOT_SEL,
    input wire logic SLEEP_REQ,
    input wire logic CORE_ACK,
    input wire logic CORE_RETI,
    output logic INT_REQ,
    output logic [VEC_W-1:0] INT_VECTOR,
    output logic [LVL_FLD_W-1:0] INT_LEVEL,
    output logic INT_NMI,
    output logic [NSRC-1:0] ACK_SRC,
    output logic NMI_ACK,
    output logic [NLVL-1:0] IN_SERVICE,
    output logic NMI_ACTIVE,
    output logic CPU_HALT,
    output logic [VEC_W-1:0] RESET_VECTOR
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [NSRC-1:0] level_mask(input logic [NSRC-1:0] pend,
                                                   input logic [LVL_FLD_W*NSRC-1:0] lvl,
                                                   input logic [1:0] code);
        logic [NSRC-1:0] m;
        m = '0;
        for (int i = 0; i < NSRC; i++)
            m[i] = pend[i] && (lvl[LVL_FLD_W*i +: LVL_FLD_W] == code);
        return m;
    endfunction

    function automatic logic [1:0] top_level(input logic [NLVL-1:0] isr);
        logic [1:0] t;
        t = LVL_OFF;
        if (isr[0])
            t = LVL_LO;
        if (isr[1])
            t = LVL_MED;
        if (isr[2])
            t = LVL_HI;
        return t;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NLVL-1:0] isr_r;
    logic [NLVL-1:0] isr_nxt;
    logic nmi_isr_r;
    logic nmi_isr_nxt;
    logic [IDX_W-1:0] rr_last_r;
    logic sel_vld_r;
    logic sel_nmi_r;
    logic [IDX_W-1:0] sel_idx_r;
    logic [1:0] sel_lvl_r;
    logic [VEC_W-1:0] sel_vec_r;
    logic [NSRC-1:0] ack_src_r;
    logic nmi_ack_r;
    logic [VEC_W-1:0] reset_vec_r;
    mic_pwr_e pwr_r;
    mic_pwr_e pwr_nxt;
    logic [2:0] hold_cnt_r;

    logic [NSRC-1:0] pend;
    logic [NLVL-1:0] grant_vld;
    logic [IDX_W-1:0] grant_idx [NLVL];
    logic sel_vld;
    logic sel_nmi;
    logic [IDX_W-1:0] sel_idx;
    logic [1:0] sel_lvl;
    logic [VEC_W-1:0] table_base;
    logic taken;

    assign pend = IRQ_REQ & IRQ_EN;

    // ------------------------------------------------------------
    // Per-level pickers
    // ------------------------------------------------------------
    mic_pick_if pk [NLVL] ();

    generate
        for (genvar g = 0; g < NLVL; g++)
        begin : g_lvl
            assign pk[g].mask = level_mask(pend, IRQ_LVL, 2'(g + 1));
            assign pk[g].rr_en = (g == 0) ? RR_EN : 1'b0;
            assign pk[g].last = (g == 0) ? rr_last_r : '0;
            assign grant_vld[g] = pk[g].vld;
            assign grant_idx[g] = pk[g].idx;
            mic_pick u_pick (
                .p(pk[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Selection across levels
    // ------------------------------------------------------------
    always_comb
    begin
        sel_vld = 1'b0;
        sel_nmi = 1'b0;
        sel_idx = '0;
        sel_lvl = LVL_OFF;
        if (NMI_REQ && !nmi_isr_r)
        begin
            sel_vld = 1'b1;
            sel_nmi = 1'b1;
        end
        else if (!nmi_isr_r)
        begin
            // Later, higher levels override lower ones.
            for (int l = 0; l < NLVL; l++)
            begin
                if (grant_vld[l] && LVL_EN[l] && 2'(l + 1) > top_level(isr_r))
                begin
                    sel_vld = 1'b1;
                    sel_idx = grant_idx[l];
                    sel_lvl = 2'(l + 1);
                end
            end
        end
    end

    assign table_base = BOOT_SEL ? BOOT_BASE : RESET_ENTRY;
    assign INT_REQ = sel_vld_r && (pwr_r == MIC_RUN);
    assign taken = INT_REQ && CORE_ACK;

    // The registered pick is dropped on acknowledge so the same source is not offered twice.
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sel_vld_r <= 1'b0;
            sel_nmi_r <= 1'b0;
            sel_idx_r <= '0;
            sel_lvl_r <= LVL_OFF;
            sel_vec_r <= RESET_ENTRY;
        end
        else
        begin
            sel_vld_r <= sel_vld && !taken;
            sel_nmi_r <= sel_nmi;
            sel_idx_r <= sel_idx;
            sel_lvl_r <= sel_lvl;
            if (sel_nmi)
                sel_vec_r <= table_base + CRYSTAL_FAIL_VECTOR;
            else
                sel_vec_r <= table_base + SRC_VEC[sel_idx];
        end
    end

    // ------------------------------------------------------------
    // In-service flags
    // ------------------------------------------------------------
    always_comb
    begin
        isr_nxt = isr_r;
        nmi_isr_nxt = nmi_isr_r;
        if (CORE_RETI)
        begin
            if (nmi_isr_r)
                nmi_isr_nxt = 1'b0;
            else if (isr_r[2])
                isr_nxt[2] = 1'b0;
            else if (isr_r[1])
                isr_nxt[1] = 1'b0;
            else
                isr_nxt[0] = 1'b0;
        end
        // A new acknowledge in the same cycle as a return still sets its flag.
        if (taken)
        begin
            if (sel_nmi_r)
                nmi_isr_nxt = 1'b1;
            else
                isr_nxt[sel_lvl_r - 2'h1] = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            isr_r <= '0;
            nmi_isr_r <= 1'b0;
        end
        else
        begin
            isr_r <= isr_nxt;
            nmi_isr_r <= nmi_isr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge outputs and round-robin pointer
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ack_src_r <= '0;
            nmi_ack_r <= 1'b0;
            rr_last_r <= IDX_W'(NSRC - 1);
        end
        else
        begin
            ack_src_r <= '0;
            nmi_ack_r <= taken && sel_nmi_r;
            if (taken && !sel_nmi_r)
                ack_src_r[sel_idx_r] <= 1'b1;
            if (taken && !sel_nmi_r && sel_lvl_r == LVL_LO)
                rr_last_r <= sel_idx_r;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            reset_vec_r <= RESET_ENTRY;
        else
            reset_vec_r <= table_base + RESET_ENTRY;
    end

    // ------------------------------------------------------------
    // Sleep and wake hold
    // ------------------------------------------------------------
    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            MIC_RUN:
                if (SLEEP_REQ)
                    pwr_nxt = MIC_NAP;
            MIC_NAP:
                if (sel_vld_r)
                    pwr_nxt = MIC_HOLD;
            MIC_HOLD:
                if (hold_cnt_r == WAKE_HOLD_CYCLES - 3'h1)
                    pwr_nxt = MIC_RUN;
            default:
                pwr_nxt = MIC_RUN;
        endcase
    end

    // Selection keeps running during the hold, so the best pending request is offered first on resume.
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pwr_r <= MIC_RUN;
            hold_cnt_r <= '0;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            if (pwr_r == MIC_HOLD)
                hold_cnt_r <= hold_cnt_r + 3'h1;
            else
                hold_cnt_r <= '0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign INT_VECTOR = sel_vec_r;
    assign INT_LEVEL = sel_lvl_r;
    assign INT_NMI = sel_nmi_r;
    assign ACK_SRC = ack_src_r;
    assign NMI_ACK = nmi_ack_r;
    assign IN_SERVICE = isr_r;
    assign NMI_ACTIVE = nmi_isr_r;
    assign CPU_HALT = (pwr_r != MIC_RUN);
    assign RESET_VECTOR = reset_vec_r;

endmodule

// ---- tb/mic_assertions.sv ----
// Concurrent checks on the ports of the multilevel interrupt controller.
module mic_assertions
    import mic_pkg::*;
#(
    parameter logic [VEC_W-1:0] BOOT_BASE = 16'h4000
)
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic BOOT_SEL,
    input wire logic SLEEP_REQ,
    input wire logic CORE_ACK,
    input wire logic CORE_RETI,
    input wire logic INT_REQ,
    input wire logic [VEC_W-1:0] INT_VECTOR,
    input wire logic [LVL_FLD_W-1:0] INT_LEVEL,
    input wire logic INT_NMI,
    input wire logic [NSRC-1:0] ACK_SRC,
    input wire logic NMI_ACK,
    input wire logic [NLVL-1:0] IN_SERVICE,
    input wire logic NMI_ACTIVE,
    input wire logic CPU_HALT,
    input wire logic [VEC_W-1:0] RESET_VECTOR
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_take;
        INT_REQ && CORE_ACK;
    endsequence
    sequence s_sleep_entry;
        !CPU_HALT && SLEEP_REQ;
    endsequence
    sequence s_halt_five;
        CPU_HALT [*5];
    endsequence

    a_take_onehot: assert property (s_take ##0 !INT_NMI |=> $onehot(ACK_SRC) && !NMI_ACK)
        else $error("maskable take without one-hot acknowledge");
    a_take_gap: assert property (s_take |=> !INT_REQ)
        else $error("offer present right after a take");
    a_insvc_set: assert property (s_take ##0 !INT_NMI |=> IN_SERVICE[$past(INT_LEVEL) - 2'h1])
        else $error("in-service flag not set after take");
    a_nmi_take: assert property (s_take ##0 INT_NMI |=> NMI_ACK && NMI_ACTIVE && ACK_SRC == '0)
        else $error("non-maskable take not recorded");
    a_nmi_vector: assert property (INT_REQ && INT_NMI |-> INT_VECTOR == RESET_VECTOR + 16'h0002)
        else $error("non-maskable vector wrong");
    a_nmi_blocks: assert property (NMI_ACTIVE |-> !INT_REQ)
        else $error("offer while non-maskable handler runs");
    a_level_above: assert property (INT_REQ && !INT_NMI |-> (IN_SERVICE >> (INT_LEVEL - 2'h1)) == 3'h0)
        else $error("offered level not above in-service levels");
    a_halt_blocks: assert property (CPU_HALT |-> !INT_REQ)
        else $error("offer while core halted");
    a_sleep_hold: assert property (s_sleep_entry |=> s_halt_five)
        else $error("halt shorter than sleep plus wake hold");
    a_boot_base: assert property (1'b1 |=> RESET_VECTOR == ($past(BOOT_SEL) ? BOOT_BASE : 16'h0000))
        else $error("reset entry does not follow table position");
    a_reti_clear: assert property (CORE_RETI && !NMI_ACTIVE && !CORE_ACK && IN_SERVICE[2]
        |=> IN_SERVICE == {1'b0, $past(IN_SERVICE[1:0])})
        else $error("return did not clear highest level");
endmodule

bind multilevel_irq_ctrl mic_assertions #(.BOOT_BASE(BOOT_BASE)) u_mic_assertions (.MCLK(MCLK),
    .RESETN(RESETN), .BOOT_SEL(BOOT_SEL), .SLEEP_REQ(SLEEP_REQ), .CORE_ACK(CORE_ACK),
    .CORE_RETI(CORE_RETI), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .INT_LEVEL(INT_LEVEL),
    .INT_NMI(INT_NMI), .ACK_SRC(ACK_SRC), .NMI_ACK(NMI_ACK), .IN_SERVICE(IN_SERVICE),
    .NMI_ACTIVE(NMI_ACTIVE), .CPU_HALT(CPU_HALT), .RESET_VECTOR(RESET_VECTOR));

// ---- tb/mic_core_model.sv ----
// Behavioural processor core that takes the offered interrupt.
module mic_core_model
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic int_req,
    input wire logic auto_take,
    input wire logic [1:0] take_dly,
    output logic core_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_r;

    // The core may answer promptly or after a few cycles.
    always @(negedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            core_ack <= 1'b0;
            wait_r <= 2'h0;
        end
        else if (auto_take && int_req && !core_ack && wait_r >= take_dly)
        begin
            core_ack <= 1'b1;
            wait_r <= 2'h0;
        end
        else
        begin
            core_ack <= 1'b0;
            wait_r <= (auto_take && int_req && wait_r != 2'h3) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule

// ---- tb/tb_multilevel_irq_ctrl.sv ----
// Self-checking testbench for the multilevel interrupt controller.
module tb_multilevel_irq_ctrl
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [15:0] TB_BOOT = 16'h4000;
    localparam logic [15:0] VEC_TBL [23] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
        16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e,
        16'h0028, 16'h0030, 16'h0032, 16'h003e, 16'h0040, 16'h0042, 16'h0044, 16'h005e, 16'h00fa};

    logic mclk, resetn, rr_en, nmi_req, boot_sel, sleep_req, core_ack, core_reti, auto_take;
    logic int_req, int_nmi, nmi_ack, nmi_active, cpu_halt;
    logic [22:0] irq_req, irq_en, ack_src;
    logic [45:0] irq_lvl;
    logic [2:0] lvl_en, in_service;
    logic [1:0] int_level, take_dly;
    logic [15:0] int_vector, reset_vector, id, base;
    logic [63:0] r64;
    int n_errors = 0, num_checks = 0, seed = 77, e, cnt;

    multilevel_irq_ctrl #(.BOOT_BASE(TB_BOOT)) u_dut (.MCLK(mclk), .RESETN(resetn), .IRQ_REQ(irq_req),
        .IRQ_EN(irq_en), .IRQ_LVL(irq_lvl), .LVL_EN(lvl_en), .RR_EN(rr_en), .NMI_REQ(nmi_req),
        .BOOT_SEL(boot_sel), .SLEEP_REQ(sleep_req), .CORE_ACK(core_ack), .CORE_RETI(core_reti),
        .INT_REQ(int_req), .INT_VECTOR(int_vector), .INT_LEVEL(int_level), .INT_NMI(int_nmi),
        .ACK_SRC(ack_src), .NMI_ACK(nmi_ack), .IN_SERVICE(in_service), .NMI_ACTIVE(nmi_active),
        .CPU_HALT(cpu_halt), .RESET_VECTOR(reset_vector));
    mic_core_model u_core (.mclk(mclk), .resetn(resetn), .int_req(int_req), .auto_take(auto_take),
        .take_dly(take_dly), .core_ack(core_ack));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        {irq_req, irq_lvl, rr_en, nmi_req, sleep_req, core_reti, boot_sel} = '0;
        irq_en = '1;
        lvl_en = 3'h7;
        step(10);
        chk({int_req, in_service, int_vector}, 20'h0);
        chk(reset_vector, 16'h0000);
        resetn = 1'b1;
        step(1);
    endtask

    // Best pending source by level, then lowest index; -1 when none.
    function automatic int exp_idx(input logic [2:0] ins);
        for (int lv = 3; lv >= 1; lv--)
            if (lvl_en[lv-1] && (ins >> (lv - 1)) == 3'h0)
                for (int i = 0; i < NSRC; i++)
                    if (irq_req[i] && irq_en[i] && irq_lvl[2*i+:2] == lv[1:0])
                        return i;
        return -1;
    endfunction

    // Lets the core take one offer; id 23 stands for the non-maskable one.
    task automatic take(input bit drop, output logic [15:0] id);
        id = 16'hffff;
        take_dly <= 2'($random(seed));
        auto_take <= 1'b1;
        for (int n = 0; n < 40 && id == 16'hffff; n++)
        begin
            step(1);
            if (nmi_ack === 1'b1)
                id = 16'd23;
            for (int i = 0; i < NSRC; i++)
                if (ack_src[i] === 1'b1)
                    id = 16'(i);
        end
        auto_take <= 1'b0;
        if (drop)
            irq_req = irq_req & ~ack_src;
        if (id == 16'hffff)
        begin
            n_errors++;
            $display("ERROR t=%0t no take seen", $time);
            complete_run();
        end
    endtask

    task automatic reti();
        core_reti = 1'b1;
        step(1);
        core_reti = 1'b0;
        step(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        {resetn, boot_sel, auto_take, take_dly} = '0;
        do_reset();
        for (int b = 0; b < 2; b++)
            for (int i = 0; i < NSRC; i++)
            begin
                boot_sel = b[0];
                irq_req = 23'h1 << i;
                irq_lvl = 46'h2 << (2 * i);
                step(1);
                chk(int_vector, (b ? TB_BOOT : 16'h0) + VEC_TBL[i]);
                chk({14'h0, int_level}, 16'h2);
                chk(reset_vector, b ? TB_BOOT : 16'h0);
            end
        for (int k = 0; k < 80; k++)
        begin
            r64 = {$random(seed), $random(seed)};
            irq_lvl = (k < 10) ? {23{2'h1}} : r64[45:0];
            r64 = {$random(seed), $random(seed)};
            {irq_req, irq_en, lvl_en, boot_sel} = r64[49:0];
            step(1);
            e = exp_idx(3'h0);
            base = boot_sel ? TB_BOOT : 16'h0;
            chk({15'h0, int_req}, {15'h0, e >= 0});
            if (e >= 0)
                chk(int_vector, base + VEC_TBL[e]);
        end
        do_reset();
        irq_lvl = 46'hc000 | 46'h800 | 46'h40 | 46'h1;
        irq_req[3] = 1'b1;
        take(1, id);
        chk(id, 16'd3);
        chk({13'h0, in_service}, 16'h1);
        irq_req[0] = 1'b1;
        step(2);
        chk({15'h0, int_req}, 16'h0);
        irq_req[5] = 1'b1;
        take(1, id);
        chk({id, 13'h0, in_service}, {16'd5, 16'h3});
        irq_req[7] = 1'b1;
        take(1, id);
        chk({id, 13'h0, in_service}, {16'd7, 16'h7});
        nmi_req = 1'b1;
        step(1);
        chk({int_nmi, int_vector}, {1'b1, 16'h0002});
        take(0, id);
        nmi_req = 1'b0;
        chk({id, 15'h0, nmi_active}, {16'd23, 16'h1});
        reti();
        chk({nmi_active, in_service}, 4'h7);
        reti();
        reti();
        chk({13'h0, in_service}, 16'h1);
        reti();
        chk({int_req, int_vector}, {1'b1, VEC_TBL[0]});
        do_reset();
        rr_en = 1'b1;
        irq_lvl = {23{2'h1}};
        irq_req = 23'h7;
        for (int j = 0; j < 7; j++)
        begin
            take(0, id);
            chk(id, 16'(j % 3));
            reti();
        end
        rr_en = 1'b0;
        take(0, id);
        chk(id, 16'd0);
        do_reset();
        irq_lvl = 46'h2000000 | 46'h10;
        sleep_req = 1'b1;
        step(1);
        sleep_req = 1'b0;
        chk({15'h0, cpu_halt}, 16'h1);
        step(3);
        irq_req = 23'h1004;
        cnt = 0;
        while (cpu_halt === 1'b1 && cnt < 20)
        begin
            step(1);
            cnt++;
        end
        chk(16'(cnt), 16'd6);
        chk({int_req, int_vector}, {1'b1, VEC_TBL[12]});
        take(1, id);
        chk(id, 16'd12);
        reti();
        take(1, id);
        chk(id, 16'd2);
        complete_run();
    end
endmodule
